/* hdl/dcsrm_pkg.sv */
// Shared constants and types for the register slave and memory read master ends
`default_nettype none
package dcsrm_pkg;
    localparam int LITE_ADDR_W   = 32;
    localparam int LITE_DATA_W   = 32;
    localparam int LITE_STRB_W   = 4;
    localparam int RESP_W        = 2;
    localparam int PROT_W        = 3;
    localparam int SPACE_SEL_BIT = 15;
    localparam int REG_IDX_W     = 4;
    localparam int REG_IDX_LSB   = 2;
    localparam int LEN_W         = 8;
    localparam int SIZE_W        = 3;
    localparam int BURST_W       = 2;
    localparam int ID_W          = 4;
    localparam int CACHE_W       = 4;
    localparam int AUSER_W       = 32;
    localparam int QNUM_LSB      = 19;
    localparam int QNUM_W        = 13;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] BURST_INCR  = 2'h1;
    localparam logic [2:0] PROT_NONE   = 3'h0;
    localparam logic [3:0] CACHE_NONE  = 4'h0;
    typedef enum logic { DCSRM_SPACE_BRIDGE, DCSRM_SPACE_ENGINE } dcsrm_space_t;
endpackage
`default_nettype wire

/* hdl/dcsrm_if.sv */
// Interface joining the register/read-master end with the user end
`timescale 1ns/1ps
`default_nettype none
interface dcsrm_if #(
    parameter int ADDR_W = 64,
    parameter int DATA_W = 256
) ();
    // Register slave write path
    logic [dcsrm_pkg::LITE_ADDR_W-1:0] awaddr;
    logic [dcsrm_pkg::PROT_W-1:0]      awprot;
    logic                              awvalid;
    logic                              awready;
    logic [dcsrm_pkg::LITE_DATA_W-1:0] wdata;
    logic [dcsrm_pkg::LITE_STRB_W-1:0] wstrb;
    logic                              wvalid;
    logic                              wready;
    logic [dcsrm_pkg::RESP_W-1:0]      bresp;
    logic                              bvalid;
    logic                              bready;
    // Register slave read path
    logic [dcsrm_pkg::LITE_ADDR_W-1:0] araddr;
    logic [dcsrm_pkg::PROT_W-1:0]      arprot;
    logic                              arvalid;
    logic                              arready;
    logic [dcsrm_pkg::LITE_DATA_W-1:0] rdata;
    logic [dcsrm_pkg::RESP_W-1:0]      rresp;
    logic                              rvalid;
    logic                              rready;
    // Memory read master address
    logic [ADDR_W-1:0]                 m_araddr;
    logic [dcsrm_pkg::ID_W-1:0]        m_arid;
    logic [dcsrm_pkg::AUSER_W-1:0]     m_aruser;
    logic [dcsrm_pkg::LEN_W-1:0]       m_arlen;
    logic [dcsrm_pkg::SIZE_W-1:0]      m_arsize;
    logic [dcsrm_pkg::BURST_W-1:0]     m_arburst;
    logic [dcsrm_pkg::PROT_W-1:0]      m_arprot;
    logic [dcsrm_pkg::CACHE_W-1:0]     m_arcache;
    logic                              m_arlock;
    logic                              m_arvalid;
    logic                              m_arready;
    // Memory read data
    logic [DATA_W-1:0]                 m_rdata;
    logic [dcsrm_pkg::ID_W-1:0]        m_rid;
    logic [dcsrm_pkg::RESP_W-1:0]      m_rresp;
    logic                              m_rlast;
    logic [DATA_W/8-1:0]               m_ruser;
    logic                              m_rvalid;
    logic                              m_rready;

    modport engine (
        input  awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
        input  araddr, arprot, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
        output m_araddr, m_arid, m_aruser, m_arlen, m_arsize, m_arburst,
        output m_arprot, m_arcache, m_arlock, m_arvalid, m_rready,
        input  m_arready, m_rdata, m_rid, m_rresp, m_rlast, m_ruser, m_rvalid
    );
    modport user (
        output awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
        output araddr, arprot, arvalid, rready,
        input  awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
        input  m_araddr, m_arid, m_aruser, m_arlen, m_arsize, m_arburst,
        input  m_arprot, m_arcache, m_arlock, m_arvalid, m_rready,
        output m_arready, m_rdata, m_rid, m_rresp, m_rlast, m_ruser, m_rvalid
    );
endinterface // dcsrm_if
`default_nettype wire

/* hdl/dcsrm_engine.sv */
// Engine end: register slave with two spaces and the memory read master
`timescale 1ns/1ps
`default_nettype none
module dcsrm_engine #(
    parameter int ADDR_W   = 64,
    parameter int DATA_W   = 256,
    parameter bit PROT_MODE = 1'b1
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // Link
    dcsrm_if.engine                              bus,
    // Engine read requests
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire logic [ADDR_W-1:0]               req_addr,
    input  wire logic [dcsrm_pkg::LEN_W-1:0]     req_len,
    input  wire logic [dcsrm_pkg::SIZE_W-1:0]    req_size,
    input  wire logic [dcsrm_pkg::ID_W-1:0]      req_id,
    input  wire logic [dcsrm_pkg::QNUM_W-1:0]    req_qnum,
    // Returned data
    output logic                                 dat_valid,
    input  wire logic                            dat_ready,
    output logic [DATA_W-1:0]                    dat_data,
    output logic [dcsrm_pkg::ID_W-1:0]           dat_id,
    output logic [dcsrm_pkg::RESP_W-1:0]         dat_resp,
    output logic                                 dat_last,
    output logic                                 dat_parity_err,
    // Word 0 of each register space, seen by the engine
    output logic [dcsrm_pkg::LITE_DATA_W-1:0]    engine_ctrl,
    output logic [dcsrm_pkg::LITE_DATA_W-1:0]    bridge_ctrl
);
    localparam int NREG = 1 << dcsrm_pkg::REG_IDX_W;
    localparam int PW   = DATA_W / 8;
    localparam int EW   = DATA_W + dcsrm_pkg::ID_W + dcsrm_pkg::RESP_W + 2;

    // Parity lanes need whole bytes; refused while elaborating, not at run time
    if (DATA_W % 8 != 0 || DATA_W < 8 || ADDR_W < 12) begin : g_bad_width
        $error("dcsrm_engine: unsupported width");
    end

    // Bit 15 chooses the register space
    function automatic dcsrm_pkg::dcsrm_space_t space_of(
        input logic [dcsrm_pkg::LITE_ADDR_W-1:0] a);
        space_of = a[dcsrm_pkg::SPACE_SEL_BIT] ? dcsrm_pkg::DCSRM_SPACE_ENGINE
                                              : dcsrm_pkg::DCSRM_SPACE_BRIDGE;
    endfunction

    // Each register space is a small word array
    logic [dcsrm_pkg::LITE_DATA_W-1:0] eng_reg  [NREG];
    logic [dcsrm_pkg::LITE_DATA_W-1:0] brg_reg  [NREG];
    logic [dcsrm_pkg::LITE_DATA_W-1:0] eng_next [NREG];
    logic [dcsrm_pkg::LITE_DATA_W-1:0] brg_next [NREG];
    logic                              bvalid_reg, bvalid_next;
    logic                              rvalid_reg, rvalid_next;
    logic [dcsrm_pkg::LITE_DATA_W-1:0] rdata_reg, rdata_next;
    logic                              wr_go, rd_go;
    logic [dcsrm_pkg::REG_IDX_W-1:0]   widx, ridx;

    // Address and data taken together; prot is never looked at
    assign wr_go = bus.awvalid && bus.wvalid && !bvalid_reg;
    assign rd_go = bus.arvalid && !rvalid_reg;
    assign widx  = bus.awaddr[dcsrm_pkg::REG_IDX_LSB +: dcsrm_pkg::REG_IDX_W];
    assign ridx  = bus.araddr[dcsrm_pkg::REG_IDX_LSB +: dcsrm_pkg::REG_IDX_W];

    always_comb begin
        eng_next    = eng_reg;
        brg_next    = brg_reg;
        bvalid_next = bvalid_reg && !bus.bready;
        rvalid_next = rvalid_reg && !bus.rready;
        rdata_next  = rdata_reg;
        if (wr_go) begin
            bvalid_next = 1'b1;
            for (int b = 0; b < dcsrm_pkg::LITE_STRB_W; b++) begin
                if (bus.wstrb[b]) begin
                    if (space_of(bus.awaddr) == dcsrm_pkg::DCSRM_SPACE_ENGINE) begin
                        eng_next[widx][8*b +: 8] = bus.wdata[8*b +: 8];
                    end else begin
                        brg_next[widx][8*b +: 8] = bus.wdata[8*b +: 8];
                    end
                end
            end
        end
        if (rd_go) begin
            rvalid_next = 1'b1;
            rdata_next  = (space_of(bus.araddr) == dcsrm_pkg::DCSRM_SPACE_ENGINE)
                          ? eng_reg[ridx] : brg_reg[ridx];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NREG; i++) begin
                eng_reg[i] <= '0;
                brg_reg[i] <= '0;
            end
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
        end else begin
            eng_reg    <= eng_next;
            brg_reg    <= brg_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign bus.awready = wr_go;
    assign bus.wready  = wr_go;
    assign bus.bvalid  = bvalid_reg;
    assign bus.bresp   = dcsrm_pkg::RESP_OKAY;
    assign bus.arready = rd_go;
    assign bus.rvalid  = rvalid_reg;
    assign bus.rdata   = rdata_reg;
    assign bus.rresp   = dcsrm_pkg::RESP_OKAY;
    assign engine_ctrl = eng_reg[0];
    assign bridge_ctrl = brg_reg[0];

    // Read address channel: one request held until accepted
    logic                            arv_reg, arv_next;
    logic [ADDR_W-1:0]               ara_reg, ara_next;
    logic [dcsrm_pkg::LEN_W-1:0]     len_reg, len_next;
    logic [dcsrm_pkg::SIZE_W-1:0]    siz_reg, siz_next;
    logic [dcsrm_pkg::ID_W-1:0]      id_reg, id_next;
    logic [dcsrm_pkg::QNUM_W-1:0]    q_reg, q_next;

    assign req_ready = !arv_reg || bus.m_arready;

    always_comb begin
        arv_next = arv_reg && !bus.m_arready;
        ara_next = ara_reg;
        len_next = len_reg;
        siz_next = siz_reg;
        id_next  = id_reg;
        q_next   = q_reg;
        if (req_valid && req_ready) begin
            arv_next = 1'b1;
            ara_next = req_addr;
            len_next = req_len;
            siz_next = req_size;
            id_next  = req_id;
            q_next   = req_qnum;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arv_reg <= 1'b0;
            ara_reg <= '0;
            len_reg <= '0;
            siz_reg <= '0;
            id_reg  <= '0;
            q_reg   <= '0;
        end else begin
            arv_reg <= arv_next;
            ara_reg <= ara_next;
            len_reg <= len_next;
            siz_reg <= siz_next;
            id_reg  <= id_next;
            q_reg   <= q_next;
        end
    end

    assign bus.m_arvalid = arv_reg;
    assign bus.m_araddr  = ara_reg;
    assign bus.m_arlen   = len_reg;
    assign bus.m_arsize  = siz_reg;
    assign bus.m_arburst = dcsrm_pkg::BURST_INCR;
    assign bus.m_arid    = id_reg;
    assign bus.m_aruser  = {q_reg, {dcsrm_pkg::QNUM_LSB{1'b0}}};
    assign bus.m_arprot  = dcsrm_pkg::PROT_NONE;
    assign bus.m_arcache = dcsrm_pkg::CACHE_NONE;
    assign bus.m_arlock  = 1'b0;

    // Two-entry skid buffer on read data so a stall downstream drops nothing
    logic [EW-1:0] buf_reg [2];
    logic [EW-1:0] buf_next [2];
    logic [1:0]    cnt_reg, cnt_next;
    logic [EW-1:0] in_word;
    logic          perr;
    logic          push, pop;

    // Odd parity: each byte plus its bit carries an odd count of ones
    always_comb begin
        perr = 1'b0;
        for (int b = 0; b < PW; b++) begin
            if (PROT_MODE && !(^{bus.m_rdata[8*b +: 8], bus.m_ruser[b]})) begin
                perr = 1'b1;
            end
        end
    end

    assign in_word      = {bus.m_rdata, bus.m_rid, bus.m_rresp, bus.m_rlast, perr};
    assign bus.m_rready = (cnt_reg != 2'h2);
    assign push         = bus.m_rvalid && bus.m_rready;
    assign pop          = dat_valid && dat_ready;

    always_comb begin
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        if (pop) begin
            buf_next[0] = buf_reg[1];
        end
        if (push) begin
            buf_next[(cnt_reg == 2'h2 || (cnt_reg == 2'h1 && !pop)) ? 1 : 0] = in_word;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            cnt_reg    <= 2'h0;
        end else begin
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
        end
    end

    assign dat_valid = (cnt_reg != 2'h0);
    assign {dat_data, dat_id, dat_resp, dat_last, dat_parity_err} = buf_reg[0];
endmodule // dcsrm_engine
`default_nettype wire

/* hdl/dcsrm_user.sv */
// User end: register master and single-beat-per-cycle memory read slave
`timescale 1ns/1ps
`default_nettype none
module dcsrm_user #(
    parameter int ADDR_W = 64,
    parameter int DATA_W = 256
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // Link
    dcsrm_if.user                                bus,
    // Register command port
    input  wire logic                            cmd_valid,
    output logic                                 cmd_ready,
    input  wire logic                            cmd_write,
    input  wire logic [dcsrm_pkg::LITE_ADDR_W-1:0] cmd_addr,
    input  wire logic [dcsrm_pkg::LITE_DATA_W-1:0] cmd_wdata,
    input  wire logic [dcsrm_pkg::LITE_STRB_W-1:0] cmd_wstrb,
    output logic                                 cmd_done,
    output logic [dcsrm_pkg::LITE_DATA_W-1:0]    cmd_rdata,
    output logic [dcsrm_pkg::RESP_W-1:0]         cmd_resp,
    // Memory read requests seen
    output logic [dcsrm_pkg::QNUM_W-1:0]         last_qnum
);
    localparam int PW = DATA_W / 8;
    typedef enum logic [1:0] { DU_IDLE, DU_REQ, DU_WAIT } dcsrm_ust_t;

    // The beat carries its own address, so the data word must hold it
    if (DATA_W % 8 != 0 || DATA_W < 8 || ADDR_W > DATA_W) begin : g_bad_width
        $error("dcsrm_user: unsupported width");
    end

    dcsrm_ust_t st_reg, st_next;
    logic       wr_reg, wr_next;
    logic [dcsrm_pkg::LITE_ADDR_W-1:0] a_reg, a_next;
    logic [dcsrm_pkg::LITE_DATA_W-1:0] d_reg, d_next;
    logic [dcsrm_pkg::LITE_STRB_W-1:0] s_reg, s_next;
    logic       done_reg, done_next;
    logic [dcsrm_pkg::LITE_DATA_W-1:0] rd_reg, rd_next;
    logic [dcsrm_pkg::RESP_W-1:0]      rs_reg, rs_next;
    logic       hand;

    assign cmd_ready = (st_reg == DU_IDLE);
    assign hand = wr_reg ? (bus.awready && bus.wready) : bus.arready;

    always_comb begin
        st_next = st_reg;
        wr_next = wr_reg;
        a_next = a_reg;
        d_next = d_reg;
        s_next = s_reg;
        done_next = 1'b0;
        rd_next = rd_reg;
        rs_next = rs_reg;
        unique case (st_reg)
            DU_IDLE: begin
                if (cmd_valid) begin
                    st_next = DU_REQ;
                    wr_next = cmd_write;
                    a_next = cmd_addr;
                    d_next = cmd_wdata;
                    s_next = cmd_wstrb;
                end
            end
            DU_REQ: begin
                if (hand) begin
                    st_next = DU_WAIT;
                end
            end
            DU_WAIT: begin
                if (wr_reg && bus.bvalid) begin
                    st_next = DU_IDLE;
                    done_next = 1'b1;
                    rs_next = bus.bresp;
                end else if (!wr_reg && bus.rvalid) begin
                    st_next = DU_IDLE;
                    done_next = 1'b1;
                    rd_next = bus.rdata;
                    rs_next = bus.rresp;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= DU_IDLE;
            wr_reg <= 1'b0;
            a_reg <= '0;
            d_reg <= '0;
            s_reg <= '0;
            done_reg <= 1'b0;
            rd_reg <= '0;
            rs_reg <= '0;
        end else begin
            st_reg <= st_next;
            wr_reg <= wr_next;
            a_reg <= a_next;
            d_reg <= d_next;
            s_reg <= s_next;
            done_reg <= done_next;
            rd_reg <= rd_next;
            rs_reg <= rs_next;
        end
    end

    // Valid held until ready, only for a real request
    assign bus.awvalid = (st_reg == DU_REQ) && wr_reg;
    assign bus.wvalid  = (st_reg == DU_REQ) && wr_reg;
    assign bus.arvalid = (st_reg == DU_REQ) && !wr_reg;
    assign bus.awaddr  = a_reg;
    assign bus.araddr  = a_reg;
    assign bus.wdata   = d_reg;
    assign bus.wstrb   = s_reg;
    assign bus.awprot  = dcsrm_pkg::PROT_NONE;
    assign bus.arprot  = dcsrm_pkg::PROT_NONE;
    assign bus.bready  = (st_reg == DU_WAIT);
    assign bus.rready  = (st_reg == DU_WAIT);
    assign cmd_done    = done_reg;
    assign cmd_rdata   = rd_reg;
    assign cmd_resp    = rs_reg;

    // Memory slave: one burst at a time, data is start address plus beat number times bytes per beat
    logic                          busy_reg, busy_next;
    logic [ADDR_W-1:0]             ma_reg, ma_next;
    logic [dcsrm_pkg::LEN_W-1:0]   left_reg, left_next;
    logic [dcsrm_pkg::ID_W-1:0]    mid_reg, mid_next;
    logic [dcsrm_pkg::QNUM_W-1:0]  q_reg, q_next;
    logic [DATA_W-1:0]             beat;

    assign bus.m_arready = !busy_reg;

    always_comb begin
        busy_next = busy_reg;
        ma_next = ma_reg;
        left_next = left_reg;
        mid_next = mid_reg;
        q_next = q_reg;
        if (!busy_reg && bus.m_arvalid) begin
            busy_next = 1'b1;
            ma_next = bus.m_araddr;
            left_next = bus.m_arlen;
            mid_next = bus.m_arid;
            q_next = bus.m_aruser[dcsrm_pkg::QNUM_LSB +: dcsrm_pkg::QNUM_W];
        end else if (busy_reg && bus.m_rready) begin
            ma_next = ma_reg + ADDR_W'(PW);
            left_next = left_reg - 8'h01;
            busy_next = (left_reg != 8'h00);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            ma_reg <= '0;
            left_reg <= '0;
            mid_reg <= '0;
            q_reg <= '0;
        end else begin
            busy_reg <= busy_next;
            ma_reg <= ma_next;
            left_reg <= left_next;
            mid_reg <= mid_next;
            q_reg <= q_next;
        end
    end

    always_comb begin
        beat = '0;
        beat[ADDR_W-1:0] = ma_reg;
    end

    genvar g;
    generate
        for (g = 0; g < PW; g++) begin : g_par
            assign bus.m_ruser[g] = ~^beat[8*g +: 8];
        end
    endgenerate

    assign bus.m_rvalid = busy_reg;
    assign bus.m_rdata  = beat;
    assign bus.m_rid    = mid_reg;
    assign bus.m_rresp  = dcsrm_pkg::RESP_OKAY;
    assign bus.m_rlast  = busy_reg && (left_reg == 8'h00);
    assign last_qnum    = q_reg;
endmodule // dcsrm_user
`default_nettype wire

/* verif/dcsrm_checker.sv */
// Concurrent checks on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module dcsrm_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Register link
    input wire logic        awvalid,
    input wire logic        wvalid,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Read master link
    input wire logic        m_arvalid,
    input wire logic        m_arready,
    input wire logic [31:0] m_aruser,
    input wire logic [1:0]  m_arburst
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
        else $error("write not answered next cycle");
    a_bresp_okay: assert property (bvalid |-> bresp == dcsrm_pkg::RESP_OKAY)
        else $error("write response not okay");
    a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped before ready");
    a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
        else $error("read not answered next cycle");
    a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");
    a_arvalid_holds: assert property (m_arvalid && !m_arready |=> m_arvalid && $stable(m_aruser))
        else $error("read request withdrawn before ready");
    a_user_reserved: assert property (m_arvalid |-> m_aruser[18:0] == 19'h0)
        else $error("reserved user bits not zero");
    a_burst_incr: assert property (m_arvalid |-> m_arburst == dcsrm_pkg::BURST_INCR)
        else $error("burst type not incrementing");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_burst: cover property (m_arvalid && m_arready);
endmodule // dcsrm_checker
`default_nettype wire

/* verif/dcsrm_tb_top.sv */
// Testbench joining both ends over the link
`timescale 1ns/1ps
`default_nettype none
`define DCSRM_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %0t got %0h exp %0h", $time, (got), (exp)); end end
module dcsrm_tb_top;
    localparam int DATA_W = 256;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    logic          req_valid = 1'b0, req_ready;
    logic [63:0]   req_addr = 64'h0;
    logic [7:0]    req_len = 8'h0;
    logic [2:0]    req_size = 3'h5;
    logic [3:0]    req_id = 4'hA;
    logic [12:0]   req_qnum = 13'h0, last_qnum;
    logic          dat_valid, dat_ready = 1'b0, dat_last, dat_parity_err;
    logic [255:0]  dat_data;
    logic [3:0]    dat_id, cap_arid;
    logic [1:0]    dat_resp, cmd_resp;
    logic [31:0]   engine_ctrl, bridge_ctrl, cmd_rdata, cap_aruser;
    logic          cmd_valid = 1'b0, cmd_ready, cmd_write = 1'b0, cmd_done;
    logic [31:0]   cmd_addr = 32'h0, cmd_wdata = 32'h0;
    logic [3:0]    cmd_wstrb = 4'h0;
    logic [7:0]    cap_arlen;
    int            failures = 0, num_checks = 0;
    dcsrm_if #(.ADDR_W(64), .DATA_W(DATA_W)) link ();
    dcsrm_engine #(.ADDR_W(64), .DATA_W(DATA_W), .PROT_MODE(1'b1)) u_dcsrm_engine (
        .sys_clk, .rst, .bus(link), .req_valid, .req_ready, .req_addr, .req_len, .req_size,
        .req_id, .req_qnum, .dat_valid, .dat_ready, .dat_data, .dat_id, .dat_resp,
        .dat_last, .dat_parity_err, .engine_ctrl, .bridge_ctrl);
    dcsrm_user #(.ADDR_W(64), .DATA_W(DATA_W)) u_dcsrm_user (
        .sys_clk, .rst, .bus(link), .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr,
        .cmd_wdata, .cmd_wstrb, .cmd_done, .cmd_rdata, .cmd_resp, .last_qnum);
    dcsrm_checker u_dcsrm_checker (
        .sys_clk, .rst, .awvalid(link.awvalid), .wvalid(link.wvalid), .bvalid(link.bvalid),
        .bready(link.bready), .bresp(link.bresp), .arvalid(link.arvalid),
        .rvalid(link.rvalid), .rready(link.rready), .rdata(link.rdata),
        .m_arvalid(link.m_arvalid), .m_arready(link.m_arready),
        .m_aruser(link.m_aruser), .m_arburst(link.m_arburst));
    always #50 sys_clk = ~sys_clk;
    // Keep the fields of the last accepted read request
    always @(posedge sys_clk) begin
        if (link.m_arvalid && link.m_arready) begin
            cap_aruser <= link.m_aruser;
            cap_arlen <= link.m_arlen;
            cap_arid <= link.m_arid;
        end
    end
    task automatic give_verdict();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_cmd(input logic wr, input logic [31:0] addr, data,
                           input logic [3:0] strb, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= addr;
        cmd_wdata <= data;
        cmd_wstrb <= strb;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        while (cmd_done !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `DCSRM_CHK(cmd_done, 1'b1)
        `DCSRM_CHK(cmd_ready, 1'b1)
        `DCSRM_CHK(cmd_resp, dcsrm_pkg::RESP_OKAY)
        rd = cmd_rdata;
    endtask
    task automatic test_reg_spaces();
        logic [31:0] rd;
        reg_cmd(1'b1, 32'h0000_8000, 32'hA5A5_A5A5, 4'hF, rd);
        reg_cmd(1'b1, 32'h0000_0000, 32'h1234_5678, 4'hF, rd);
        // Only the low byte lane is enabled here
        reg_cmd(1'b1, 32'h0000_8000, 32'hFFFF_FFFF, 4'h1, rd);
        `DCSRM_CHK(engine_ctrl, 32'hA5A5_A5FF)
        `DCSRM_CHK(bridge_ctrl, 32'h1234_5678)
        reg_cmd(1'b0, 32'h0000_8040, 32'h0, 4'h0, rd);
        `DCSRM_CHK(rd, 32'hA5A5_A5FF)
        reg_cmd(1'b0, 32'h0000_0000, 32'h0, 4'h0, rd);
        `DCSRM_CHK(rd, 32'h1234_5678)
        $display("test_reg_spaces done");
    endtask
    task automatic test_burst(input logic [63:0] addr, input logic [7:0] len,
                              input logic [12:0] qnum, input int stall);
        int i;
        int n;
        i = 0;
        n = 0;
        @(posedge sys_clk);
        dat_ready <= 1'b0;
        req_valid <= 1'b1;
        req_addr <= addr;
        req_len <= len;
        req_qnum <= qnum;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        repeat (stall) @(posedge sys_clk);
        #1;
        // A long stall must fill both entries and hold the slave off
        if (stall > 0) `DCSRM_CHK(link.m_rready, 1'b0)
        @(posedge sys_clk);
        dat_ready <= 1'b1;
        #1;
        while (i <= len && n < 50) begin
            if (dat_valid === 1'b1) begin
                `DCSRM_CHK(dat_data, DATA_W'(addr + 64'(i) * 64'h20))
                `DCSRM_CHK(dat_id, 4'hA)
                `DCSRM_CHK(dat_resp, dcsrm_pkg::RESP_OKAY)
                `DCSRM_CHK(dat_last, (i == int'(len)))
                `DCSRM_CHK(dat_parity_err, 1'b0)
                i++;
            end
            @(posedge sys_clk);
            #1;
            n++;
        end
        // A burst that never completes leaves the beat count short
        `DCSRM_CHK(i, int'(len) + 1)
        `DCSRM_CHK(dat_valid, 1'b0)
        `DCSRM_CHK(req_ready, 1'b1)
        `DCSRM_CHK(cap_aruser, {qnum, 19'h0})
        `DCSRM_CHK(cap_arlen, len)
        `DCSRM_CHK(cap_arid, 4'hA)
        `DCSRM_CHK(last_qnum, qnum)
        $display("test_burst done at %0h", addr);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        test_reg_spaces();
        test_burst(64'h0000_0000_0000_1000, 8'h03, 13'h1FFF, 10);
        test_burst(64'h0000_0000_0000_2040, 8'h00, 13'h0001, 0);
        `DCSRM_CHK($bits(link.m_ruser), DATA_W / 8)
        give_verdict();
    end
    initial begin
        #200_000;
        failures++;
        give_verdict();
    end
endmodule // dcsrm_tb_top
`default_nettype wire
